// ### hw/gpio_port.v
// APB pin port: grouped and per-pin output data, pad inputs, function mux
//
// How it works
// - Four 32-bit grouped output registers hold legacy output data, one bit per pin outside the top group.
// - Bit 16 of each pin control register is a data value that can drive the pin.
// - Bit 17 of a pin control register picks that bit over the grouped bit.
// - Reading a pin control register returns at bit 16 the value last written.
// - Reading a pin control register returns at bit 24 the live pad level.
// - Each pin is named by a three-digit octal index counting up from zero.
// - Index is 32 times input register number plus bit, five registers in all.
// - Bit 31 of each input register has no pin; indices like 037 do not exist.
// - The mux field of a pin control register picks the function on the pin.
// - Every pin has its own control register addressed by its index.
// - Each pin offers four functions, code 00 always being the pin port itself.
`timescale 1ns/1ns
`include "gpio_defs.vh"

module gpio_port (
   sys_clk,
   rst_b,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   pad_in,
   pad_out,
   pad_oe,
   alt_out,
   alt_oe,
   alt_in
);
   input wire sys_clk;
   input wire rst_b;
   input wire psel;
   input wire penable;
   input wire pwrite;
   input wire [`GP_ADDR_W-1:0] paddr;
   input wire [31:0] pwdata;
   output reg [31:0] prdata;
   output reg pready;
   output reg pslverr;
   input wire [`GP_NUM_SLOTS-1:0] pad_in;
   output wire [`GP_NUM_SLOTS-1:0] pad_out;
   output wire [`GP_NUM_SLOTS-1:0] pad_oe;
   input wire [3*`GP_NUM_SLOTS-1:0] alt_out;
   input wire [3*`GP_NUM_SLOTS-1:0] alt_oe;
   output wire [3*`GP_NUM_SLOTS-1:0] alt_in;

   // True where an index names a real pin (bit 31 slots skipped)
   function slot_exists;
      input [`GP_SLOT_W-1:0] idx;
      begin
         slot_exists = (idx < `GP_NUM_SLOTS) && (idx[4:0] != 5'h1F);
      end
   endfunction

   wire access;
   wire commit;
   wire ctrl_hit;
   wire out_hit;
   wire in_hit;
   wire addr_hit;
   wire [`GP_SLOT_W-1:0] ctrl_idx;
   wire [1:0] out_sel;
   wire [2:0] in_sel;
   wire [`GP_NUM_SLOTS-1:0] grp_bus;
   wire [32*`GP_NUM_SLOTS-1:0] ctrl_bus;
   wire [32*`GP_NUM_GROUPS-1:0] in_bus;
   wire [`GP_NUM_SLOTS-1:0] slot_we;
   wire [`GP_NUM_OUT_REGS-1:0] out_we;
   reg [31:0] rd_nxt;

   // Address decode; pin control word address is its index
   assign access = psel && penable;
   assign ctrl_idx = paddr[`GP_SLOT_W+1:2];
   assign ctrl_hit = (paddr < `GP_CTRL_END) && slot_exists(ctrl_idx);
   assign out_hit = (paddr >= `GP_OUT_BASE) && (paddr < `GP_OUT_END);
   assign in_hit = (paddr >= `GP_IN_BASE) && (paddr < `GP_IN_END);
   assign out_sel = paddr[3:2];
   assign in_sel = paddr[4:2];
   assign addr_hit = (paddr[1:0] == 2'h0) && (ctrl_hit || out_hit || in_hit);
   assign commit = access && pready && pwrite && addr_hit; // Write lands on ready edge

   // Legacy grouped output registers
   genvar g;
   generate
      for (g = 0; g < `GP_NUM_OUT_REGS; g = g + 1)
      begin : out_grp
         assign out_we[g] = commit && out_hit && (out_sel == g);
         group_out_reg u_out (
            .sys_clk(sys_clk),
            .rst_b(rst_b),
            .wr_en(out_we[g]),
            .wdata(pwdata),
            .q_r(grp_bus[32*g +: 32])
         );
      end
   endgenerate

   // Top group has no legacy register; its pins drive per-pin data with bit 17 set, else zero
   assign grp_bus[`GP_NUM_SLOTS-1:32*`GP_NUM_OUT_REGS] = 32'h00000000;

   // Input registers: index = 32 * register + bit
   generate
      for (g = 0; g < `GP_NUM_GROUPS; g = g + 1)
      begin : in_grp
         assign in_bus[32*g +: 32] = {1'b0, pad_in[32*g +: 31]};
      end
   endgenerate

   // One slice per pin index; missing indices drive nothing
   genvar i;
   generate
      for (i = 0; i < `GP_NUM_SLOTS; i = i + 1)
      begin : pin
         if (slot_exists(i))
         begin : real_pin
            assign slot_we[i] = commit && ctrl_hit && (ctrl_idx == i);
            pin_slice u_pin (
               .sys_clk(sys_clk),
               .rst_b(rst_b),
               .wr_en(slot_we[i]),
               .wdata(pwdata),
               .grp_bit(grp_bus[i]),
               .pad_in(pad_in[i]),
               .alt_out(alt_out[3*i +: 3]),
               .alt_oe(alt_oe[3*i +: 3]),
               .ctrl_rd(ctrl_bus[32*i +: 32]),
               .pad_out_r(pad_out[i]),
               .pad_oe_r(pad_oe[i]),
               .alt_in_r(alt_in[3*i +: 3])
            );
         end
         else
         begin : no_pin
            assign slot_we[i] = 1'b0;
            assign ctrl_bus[32*i +: 32] = 32'h00000000;
            assign pad_out[i] = 1'b0;
            assign pad_oe[i] = 1'b0;
            assign alt_in[3*i +: 3] = 3'h0;
         end
      end
   endgenerate

   // Read data selection
   always @*
   begin
      rd_nxt = 32'h00000000;
      if (!addr_hit)
      begin
         rd_nxt = 32'h00000000;
      end
      else if (ctrl_hit)
      begin
         rd_nxt = ctrl_bus[32*ctrl_idx +: 32];
      end
      else if (out_hit)
      begin
         rd_nxt = grp_bus[32*out_sel +: 32];
      end
      else
      begin
         rd_nxt = in_bus[32*in_sel +: 32];
      end
   end

   // APB answer: one wait state, then ready with data and error
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else if (access && !pready)
      begin
         pready <= 1'b1;
         pslverr <= !addr_hit;
         prdata <= pwrite ? 32'h00000000 : rd_nxt;
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule

// ### hw/gpio_defs.vh
// Register map, field positions and reset values of the pin port
`ifndef GPIO_DEFS_VH
`define GPIO_DEFS_VH

// Geometry
`define GP_NUM_GROUPS 5
`define GP_NUM_OUT_REGS 4
`define GP_NUM_SLOTS 160
`define GP_SLOT_W 8
`define GP_ADDR_W 12

// Byte addresses of the register areas
`define GP_CTRL_BASE 12'h000
`define GP_CTRL_END 12'h280
`define GP_OUT_BASE 12'h280
`define GP_OUT_END 12'h290
`define GP_IN_BASE 12'h300
`define GP_IN_END 12'h314

// Pin control register fields
`define GP_MUX_LSB 12
`define GP_MUX_MSB 13
`define GP_DIR_BIT 9
`define GP_ODATA_BIT 16
`define GP_OSEL_BIT 17
`define GP_PADIN_BIT 24
`define GP_RSVD_BIT 31

// Multiplexer codes
`define GP_MUX_GPIO 2'h0
`define GP_MUX_ALT1 2'h1
`define GP_MUX_ALT2 2'h2
`define GP_MUX_ALT3 2'h3

// Reset values
`define GP_CTRL_RST 32'h00000000
`define GP_OUT_RST 32'h00000000

`endif

// ### hw/group_out_reg.v
// Legacy grouped 32-bit output register
`timescale 1ns/1ns
`include "gpio_defs.vh"

module group_out_reg (
   sys_clk,
   rst_b,
   wr_en,
   wdata,
   q_r
);
   input wire sys_clk;
   input wire rst_b;
   input wire wr_en;
   input wire [31:0] wdata;
   output reg [31:0] q_r;

   // Whole word written; no per-bit mask, bit 31 holds no pin
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         q_r <= `GP_OUT_RST;
      end
      else if (wr_en)
      begin
         q_r <= {1'b0, wdata[30:0]}; // Reserved slot kept at zero
      end
   end
endmodule

// ### hw/pin_slice.v
// One pin: its control register, output source choice and function mux
`timescale 1ns/1ns
`include "gpio_defs.vh"

module pin_slice (
   sys_clk,
   rst_b,
   wr_en,
   wdata,
   grp_bit,
   pad_in,
   alt_out,
   alt_oe,
   ctrl_rd,
   pad_out_r,
   pad_oe_r,
   alt_in_r
);
   input wire sys_clk;
   input wire rst_b;
   input wire wr_en;
   input wire [31:0] wdata;
   input wire grp_bit;
   input wire pad_in;
   input wire [2:0] alt_out;
   input wire [2:0] alt_oe;
   output wire [31:0] ctrl_rd;
   output reg pad_out_r;
   output reg pad_oe_r;
   output reg [2:0] alt_in_r;

   reg [1:0] mux_r;
   reg dir_r;
   reg odata_r;
   reg osel_r;
   reg gpio_val;
   reg out_nxt;
   reg oe_nxt;
   reg [2:0] alt_in_nxt;
   integer k;

   // Control fields, all writable by firmware
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mux_r <= `GP_MUX_GPIO; // Reset code picks the port function
         dir_r <= 1'b0;
         odata_r <= 1'b0;
         osel_r <= 1'b0;
      end
      else if (wr_en)
      begin
         mux_r <= wdata[`GP_MUX_MSB:`GP_MUX_LSB];
         dir_r <= wdata[`GP_DIR_BIT];
         odata_r <= wdata[`GP_ODATA_BIT];
         osel_r <= wdata[`GP_OSEL_BIT];
      end
   end

   // Output source choice and function selection
   always @*
   begin
      gpio_val = osel_r ? odata_r : grp_bit;
      out_nxt = 1'b0;
      oe_nxt = 1'b0;
      alt_in_nxt = 3'h0;
      case (mux_r)
         `GP_MUX_GPIO:
         begin
            out_nxt = gpio_val;
            oe_nxt = dir_r;
         end
         `GP_MUX_ALT1:
         begin
            out_nxt = alt_out[0];
            oe_nxt = alt_oe[0];
         end
         `GP_MUX_ALT2:
         begin
            out_nxt = alt_out[1];
            oe_nxt = alt_oe[1];
         end
         `GP_MUX_ALT3:
         begin
            out_nxt = alt_out[2];
            oe_nxt = alt_oe[2];
         end
         default:
         begin
            out_nxt = 1'b0;
            oe_nxt = 1'b0;
         end
      endcase
      // Pad level reaches only the selected alternate function
      for (k = 0; k < 3; k = k + 1)
      begin
         alt_in_nxt[k] = pad_in && (mux_r == k + 1);
      end
   end

   // Pad and function outputs from flops
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pad_out_r <= 1'b0;
         pad_oe_r <= 1'b0;
         alt_in_r <= 3'h0;
      end
      else
      begin
         pad_out_r <= out_nxt;
         pad_oe_r <= oe_nxt;
         alt_in_r <= alt_in_nxt;
      end
   end

   // Read image: stored data bit, select, live pad level
   assign ctrl_rd = {7'h00, pad_in, 6'h00, osel_r, odata_r, 2'h0, mux_r,
                     2'h0, dir_r, 9'h000};
endmodule

// ### tb/gpio_port_chk.sv
// Checker of bus timing, register layout and pad gaps of the pin port
`timescale 1ns/1ns
module gpio_port_chk (
   input wire sys_clk,
   input wire rst_b,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [159:0] pad_in,
   input wire [159:0] pad_out,
   input wire [159:0] pad_oe
);
   // Access decode
   wire acc = psel && penable && !pready;
   wire rdd = pready && !pwrite;
   wire pin = paddr < 12'h280 && paddr[1:0] == 2'h0;
   wire gap = paddr[6:2] == 5'h1F;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_ready_next: assert property (acc |=> pready)
      else $error("no ready after access");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready too long");
   a_no_stray: assert property (!(psel && penable) |=> !pready)
      else $error("ready without access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_hole_refused: assert property (acc && pin && gap |=> pslverr && prdata == 32'h0)
      else $error("missing index answered");
   a_pin_mapped: assert property (acc && pin && !gap |=> !pslverr)
      else $error("pin register refused");
   a_pad_level: assert property (acc && !pwrite && pin && !gap |=>
      prdata[24] == $past(pad_in[paddr[9:2]]))
      else $error("pad level bit wrong");
   a_ctrl_spare: assert property (rdd && pin |-> (prdata & 32'hFEFCCDFF) == 32'h0)
      else $error("spare control bits set");
   a_in_word: assert property (rdd && paddr inside {[12'h300:12'h310]}
      && paddr[1:0] == 2'h0 |-> prdata == {1'b0, $past(pad_in[32 * paddr[4:2] +: 31])})
      else $error("input word wrong");
   a_out_top: assert property (rdd && paddr inside {[12'h280:12'h28C]} |-> !prdata[31])
      else $error("grouped top bit set");
   a_gap_quiet: assert property (((pad_out | pad_oe) & {5{32'h80000000}}) == '0)
      else $error("missing pin driven");

   c_write: cover property (acc && pwrite);
   c_refused: cover property (pready && pslverr);
   c_inword: cover property (rdd && paddr == 12'h310);
endmodule

bind gpio_port gpio_port_chk chk (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe);

// ### tb/pad_model.sv
// Pad model: a driven pad reads back its own level, else the board level
`timescale 1ns/1ns
module pad_model (
   input wire [159:0] pad_out,
   input wire [159:0] pad_oe,
   input wire [159:0] board,
   output wire [159:0] pad_in
);
   // Level seen at each pad
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & board);
endmodule

// ### tb/gpio_port_test.sv
// Bench of the pin port: bus accesses, output sources, inputs, mux codes
`timescale 1ns/1ns
module gpio_port_test;
   logic sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [159:0] board = '0;
   logic [479:0] alt_out = '0, alt_oe = '0;
   wire [31:0] prdata;
   wire pready, pslverr;
   wire [159:0] pad_in, pad_out, pad_oe;
   wire [479:0] alt_in;
   int n_fail = 0, n_compared = 0, k;
   int pins[3] = '{1, 40, 130};

   // Clock
   always #10 sys_clk = ~sys_clk;

   gpio_port uut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .alt_out, .alt_oe, .alt_in);
   pad_model pm (.pad_out, .pad_oe, .board, .pad_in);

   // One bus transfer; answer left in rd and er
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge sys_clk);
         penable <= 1'b1;
         do
         begin
            @(posedge sys_clk);
            n++;
         end
         while (pready !== 1'b1 && n < 20);
         if (n >= 20)
         begin
            n_fail++;
            conclude;
         end
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge sys_clk);
      end
   endtask

   task settle;
      repeat (3) @(posedge sys_clk);
   endtask

   task chk(input logic [35:0] s, input logic [35:0] e);
      n_compared++;
      if (s !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
      end
   endtask

   task conclude;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 12'h280, 32'hFFFFFFFF);
      apb(1'b0, 12'h280, 32'h0);
      chk(rd, 32'h7FFFFFFF);
      apb(1'b1, 12'h000, 32'h00000200);
      settle;
      chk({pad_oe[0], pad_out[0]}, 2'h3);
      // Per-pin source, data low then high
      apb(1'b1, 12'h000, 32'h00020200);
      settle;
      chk(pad_out[0], 1'b0);
      apb(1'b1, 12'h000, 32'h00030200);
      settle;
      chk(pad_out[0], 1'b1);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h01030200);
      // Clear grouped bit 0 only, then fall back to it; pin 1 keeps its bit
      apb(1'b0, 12'h280, 32'h0);
      apb(1'b1, 12'h280, rd & 32'hFFFFFFFE);
      apb(1'b1, 12'h000, 32'h00000200);
      settle;
      chk(pad_out[1:0], 2'h2);
      // Pad level shown while data bit reads low
      board[0] <= 1'b1;
      apb(1'b1, 12'h000, 32'h00020000);
      settle;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h01020000);
      // Input words
      board <= 160'hF0E1D2C3B4A5968778695A4B3C2D1E0FFEDCBA9A;
      settle;
      for (k = 0; k < 5; k++)
      begin
         apb(1'b0, 12'h300 + 12'(4 * k), 32'h0);
         chk(rd, {1'b0, board[32 * k +: 31]});
      end
      // Missing indices, misaligned and unmapped places
      for (k = 0; k < 5; k++)
      begin
         apb(1'b1, 12'h07C + 12'(128 * k), 32'hFFFFFFFF);
         apb(1'b0, 12'h07C + 12'(128 * k), 32'h0);
         chk({er, rd}, 33'h100000000);
      end
      apb(1'b0, 12'h002, 32'h0);
      chk(er, 1'b1);
      apb(1'b0, 12'h290, 32'h0);
      chk(er, 1'b1);
      // Pins 1, 40 and 130 each have their own register and pad
      board <= '0;
      for (k = 0; k < 3; k++)
         apb(1'b1, 12'(4 * pins[k]), 32'h00030200);
      settle;
      for (k = 0; k < 3; k++)
      begin
         chk(pad_out[pins[k] - 1 +: 2], 2'h2);
         apb(1'b0, 12'(4 * pins[k]), 32'h0);
         chk(rd, 32'h01030200);
      end
      // Alternate codes on pin 2
      alt_out[8:6] <= 3'h5;
      alt_oe[8:6] <= 3'h7;
      for (k = 1; k < 4; k++)
      begin
         apb(1'b1, 12'h008, 32'h01000000 | (k << 12));
         settle;
         chk({pad_oe[2], pad_out[2]}, {1'b1, alt_out[5 + k]});
         chk(alt_in[8:6], 3'(alt_out[5 + k]) << (k - 1));
      end
      // Pin 2 is a plain port pin, so code 00 may be set on it
      apb(1'b1, 12'h008, 32'h01000000);
      settle;
      apb(1'b0, 12'h008, 32'h0);
      chk({rd, pad_oe[2], alt_in[8:6]}, 36'h0);
      conclude;
   end

   // Watchdog
   initial
   begin
      #200000;
      n_fail++;
      conclude;
   end
endmodule
